// *** design/cfgrd_pkg.sv ***
// constants, states and carriers of the configuration read responder
package cfgrd_pkg;

  localparam logic [7:0]  FUNC_READ_CFG  = 8'h14;
  localparam logic [7:0]  REF_TYPE       = 8'h06;
  localparam logic [7:0]  FILE_HI        = 8'h00;
  localparam logic [7:0]  FILE_VALUE     = 8'h03; // parameter_value entry
  localparam logic [7:0]  ADDR_HI        = 8'h00;
  localparam logic [7:0]  TAG_FLOAT_MIN  = 8'h01;
  localparam logic [7:0]  TAG_FLOAT_MAX  = 8'h7D;
  localparam logic [7:0]  TAG_INT_MIN    = 8'h80;
  localparam logic [7:0]  REG_CNT_HI     = 8'h00;
  localparam logic [7:0]  REG_CNT_INT    = 8'h01;
  localparam logic [7:0]  REG_CNT_FLOAT  = 8'h02;
  localparam logic [7:0]  SUB_CNT_FLOAT  = 8'h05;
  localparam logic [7:0]  SUB_CNT_INT    = 8'h03;
  localparam logic [7:0]  SUB_LEN_FLOAT  = 8'h06;
  localparam logic [7:0]  SUB_LEN_INT    = 8'h04;
  localparam logic [7:0]  BCNT_NONE      = 8'h00;
  localparam logic [7:0]  REM_LAST       = 8'h01;

  localparam int          MAX_ITEMS      = 8;
  localparam int          ITEM_W         = 4;
  localparam logic [7:0]  MAX_REQ_BCNT   = 8'h38; // seven bytes per item

  // byte positions within an item sub-request
  localparam logic [2:0]  IB_REF         = 3'h0;
  localparam logic [2:0]  IB_FILE_HI     = 3'h1;
  localparam logic [2:0]  IB_FILE_LO     = 3'h2;
  localparam logic [2:0]  IB_ADDR_HI     = 3'h3;
  localparam logic [2:0]  IB_TAG         = 3'h4;
  localparam logic [2:0]  IB_CNT_HI      = 3'h5;
  localparam logic [2:0]  IB_CNT_LO      = 3'h6;
  // byte positions within the response header, a sub response and the checksum
  localparam logic [2:0]  HB_ADDR        = 3'h0;
  localparam logic [2:0]  HB_FUNC        = 3'h1;
  localparam logic [2:0]  HB_BCNT        = 3'h2;
  localparam logic [2:0]  SB_CNT         = 3'h0;
  localparam logic [2:0]  SB_REF         = 3'h1;
  localparam logic [2:0]  SB_LAST_INT    = 3'h3;
  localparam logic [2:0]  SB_LAST_FLOAT  = 3'h5;
  localparam logic [2:0]  CB_LO          = 3'h0;
  localparam logic [2:0]  CB_HI          = 3'h1;
  localparam logic [2:0]  IDX_ZERO       = 3'h0;
  localparam logic [2:0]  IDX_ONE        = 3'h1;

  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] INT_PAD        = 16'h0000;

  typedef enum logic [11:0] {
    ST_ADDR  = 12'h001,
    ST_FUNC  = 12'h002,
    ST_BCNT  = 12'h004,
    ST_ITEM  = 12'h008,
    ST_CRCL  = 12'h010,
    ST_CRCH  = 12'h020,
    ST_WAIT  = 12'h040,
    ST_DROP  = 12'h080,
    ST_HDR   = 12'h100,
    ST_FETCH = 12'h200,
    ST_SUB   = 12'h400,
    ST_TXCRC = 12'h800
  } cfgrd_state_e;

  typedef struct packed {
    logic       is_float;
    logic [7:0] tag;
  } cfgrd_item_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cfgrd_byte_s;

  function automatic logic tag_is_float(input logic [7:0] t);
    return (t >= TAG_FLOAT_MIN) && (t <= TAG_FLOAT_MAX);
  endfunction : tag_is_float

  function automatic logic tag_is_int(input logic [7:0] t);
    return t >= TAG_INT_MIN;
  endfunction : tag_is_int

endpackage : cfgrd_pkg

// *** design/cfgrd_crc16.sv ***
// running crc16 over a byte stream, low byte sent first
`timescale 1ns/1ps
module cfgrd_crc16
  import cfgrd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc_q
);

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // init with en restarts the sum on the first byte of a message
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= CRC_INIT;
    end else if (en) begin
      crc_q <= crc_step(init ? CRC_INIT : crc_q, data);
    end else if (init) begin
      crc_q <= CRC_INIT;
    end
  end

endmodule : cfgrd_crc16

// *** design/cfgrd_responder.sv ***
// read-configuration-reference request parser and response generator
`timescale 1ns/1ps
module cfgrd_responder
  import cfgrd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  dev_addr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_frame_end,
  output logic             tx_valid_q,
  output logic      [7:0]  tx_data_q,
  input  wire logic        tx_ready,
  output logic      [7:0]  param_tag_q,
  input  wire logic [31:0] param_value,
  output logic             resp_active_q
);

  cfgrd_state_e            state_q;
  logic        [2:0]       idx_q;
  logic        [ITEM_W-1:0] item_q;
  logic        [ITEM_W-1:0] nitems_q;
  logic        [7:0]       rem_q;
  logic        [7:0]       resp_bcnt_q;
  logic        [31:0]      val_q;
  cfgrd_item_s             items_q [MAX_ITEMS];
  cfgrd_item_s             cur_item;
  cfgrd_byte_s             tx_byte;
  logic        [15:0]      rx_crc;
  logic        [15:0]      tx_crc;
  logic                    item_byte_ok;
  logic                    rx_state;
  logic                    can_load;
  logic                    load;
  logic        [2:0]       sub_last;

  assign cur_item = items_q[item_q[ITEM_W-2:0]];
  assign rx_state = state_q inside {ST_FUNC, ST_BCNT, ST_ITEM,
                                    ST_CRCL, ST_CRCH};
  assign can_load = !tx_valid_q || tx_ready;
  assign load     = can_load && tx_byte.valid;
  assign sub_last = cur_item.is_float ? SB_LAST_FLOAT : SB_LAST_INT;

  // field checks for one byte of an item sub-request
  always_comb begin
    case (idx_q)
      IB_REF:     item_byte_ok = rx_data == REF_TYPE;
      IB_FILE_HI: item_byte_ok = rx_data == FILE_HI;
      IB_FILE_LO: item_byte_ok = rx_data == FILE_VALUE;
      IB_ADDR_HI: item_byte_ok = rx_data == ADDR_HI;
      IB_TAG:     item_byte_ok = tag_is_float(rx_data)
                               || tag_is_int(rx_data);
      IB_CNT_HI:  item_byte_ok = rx_data == REG_CNT_HI;
      IB_CNT_LO:  item_byte_ok = rx_data == (cur_item.is_float
                               ? REG_CNT_FLOAT : REG_CNT_INT);
      default:    item_byte_ok = 1'b0;
    endcase
  end

  // byte offered to the link by the response states
  always_comb begin
    tx_byte = '{valid: 1'b0, data: 8'h00};
    case (state_q)
      ST_HDR: begin
        tx_byte.valid = 1'b1;
        case (idx_q)
          HB_ADDR: tx_byte.data = dev_addr;
          HB_FUNC: tx_byte.data = FUNC_READ_CFG;
          default: tx_byte.data = resp_bcnt_q;
        endcase
      end
      ST_SUB: begin
        tx_byte.valid = 1'b1;
        case (idx_q)
          SB_CNT:  tx_byte.data = cur_item.is_float
                                  ? SUB_CNT_FLOAT : SUB_CNT_INT;
          SB_REF:  tx_byte.data = REF_TYPE;
          default: tx_byte.data = val_q[31:24];
        endcase
      end
      ST_TXCRC: begin
        tx_byte.valid = 1'b1;
        tx_byte.data  = (idx_q == CB_LO) ? tx_crc[7:0]
                                         : tx_crc[15:8];
      end
      default: tx_byte = '{valid: 1'b0, data: 8'h00};
    endcase
  end

  // message sequencing; rx bytes are ignored while a response goes out
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_ADDR;
    end else if (rx_state && rx_frame_end && !rx_valid) begin
      state_q <= ST_ADDR;
    end else begin
      case (state_q)
        ST_ADDR: if (rx_valid) begin
          state_q <= (rx_data == dev_addr) ? ST_FUNC : ST_DROP;
        end
        ST_FUNC: if (rx_valid) begin
          state_q <= (rx_data == FUNC_READ_CFG) ? ST_BCNT : ST_DROP;
        end
        ST_BCNT: if (rx_valid) begin
          state_q <= (rx_data == BCNT_NONE || rx_data > MAX_REQ_BCNT)
                     ? ST_DROP : ST_ITEM;
        end
        ST_ITEM: if (rx_valid) begin
          if (!item_byte_ok) begin
            state_q <= ST_DROP;
          end else if (rem_q == REM_LAST) begin
            state_q <= (idx_q == IB_CNT_LO) ? ST_CRCL : ST_DROP;
          end
        end
        ST_CRCL: if (rx_valid) begin
          state_q <= (rx_data == rx_crc[7:0]) ? ST_CRCH : ST_DROP;
        end
        ST_CRCH: if (rx_valid) begin
          state_q <= (rx_data == rx_crc[15:8]) ? ST_WAIT : ST_DROP;
        end
        ST_WAIT: begin
          if (rx_valid) begin
            state_q <= ST_DROP;
          end else if (rx_frame_end) begin
            state_q <= ST_HDR;
          end
        end
        ST_DROP: if (rx_frame_end) begin
          state_q <= ST_ADDR;
        end
        ST_HDR: if (load && idx_q == HB_BCNT) begin
          state_q <= ST_FETCH;
        end
        ST_FETCH: if (idx_q == IDX_ONE) begin
          state_q <= ST_SUB;
        end
        ST_SUB: if (load && idx_q == sub_last) begin
          state_q <= (item_q == nitems_q - 1'b1) ? ST_TXCRC : ST_FETCH;
        end
        ST_TXCRC: if (load && idx_q == CB_HI) begin
          state_q <= ST_ADDR;
        end
        default: state_q <= ST_ADDR;
      endcase
    end
  end

  // byte index within item, header, sub response or checksum
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= IDX_ZERO;
    end else begin
      case (state_q)
        ST_BCNT:  idx_q <= IDX_ZERO;
        ST_ITEM:  if (rx_valid) begin
          idx_q <= (idx_q == IB_CNT_LO) ? IDX_ZERO : idx_q + IDX_ONE;
        end
        ST_WAIT:  idx_q <= IDX_ZERO;
        ST_HDR:   if (load) begin
          idx_q <= (idx_q == HB_BCNT) ? IDX_ZERO : idx_q + IDX_ONE;
        end
        ST_FETCH: idx_q <= (idx_q == IDX_ONE) ? IDX_ZERO : IDX_ONE;
        ST_SUB:   if (load) begin
          idx_q <= (idx_q == sub_last) ? IDX_ZERO : idx_q + IDX_ONE;
        end
        ST_TXCRC: if (load) begin
          idx_q <= (idx_q == CB_HI) ? IDX_ZERO : idx_q + IDX_ONE;
        end
        default:  idx_q <= IDX_ZERO;
      endcase
    end
  end

  // request bookkeeping: remaining bytes, item list, response length
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      item_q      <= '0;
      nitems_q    <= '0;
      rem_q       <= BCNT_NONE;
      resp_bcnt_q <= BCNT_NONE;
      for (int i = 0; i < MAX_ITEMS; i++) begin
        items_q[i] <= '0;
      end
    end else begin
      if (state_q == ST_BCNT && rx_valid) begin
        rem_q       <= rx_data;
        item_q      <= '0;
        resp_bcnt_q <= BCNT_NONE;
      end
      if (state_q == ST_ITEM && rx_valid) begin
        rem_q <= rem_q - REM_LAST;
        if (idx_q == IB_TAG) begin
          items_q[item_q[ITEM_W-2:0]] <=
            '{is_float: tag_is_float(rx_data),
              tag:      rx_data};
        end
        if (idx_q == IB_CNT_LO) begin
          item_q      <= item_q + 1'b1;
          resp_bcnt_q <= resp_bcnt_q + (cur_item.is_float
                         ? SUB_LEN_FLOAT : SUB_LEN_INT);
        end
      end
      if (state_q == ST_WAIT && rx_frame_end && !rx_valid) begin
        nitems_q <= item_q;
        item_q   <= '0;
      end
      if (state_q == ST_SUB && load && idx_q == sub_last) begin
        item_q <= item_q + 1'b1;
      end
    end
  end

  // value lookup: tag stands one full cycle before the value is taken
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_tag_q <= 8'h00;
      val_q       <= 32'h0000_0000;
    end else begin
      // the tag moves only when a value is wanted, never while receiving
      if (state_q == ST_FETCH && idx_q == IDX_ZERO) begin
        param_tag_q <= cur_item.tag;
      end
      if (state_q == ST_FETCH && idx_q == IDX_ONE) begin
        val_q <= cur_item.is_float ? param_value
                 : {param_value[15:0], INT_PAD};
      end else if (state_q == ST_SUB && load && idx_q > SB_REF) begin
        val_q <= {val_q[23:0], 8'h00};
      end
    end
  end

  // output byte register with ready back-pressure
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_q    <= 1'b0;
      tx_data_q     <= 8'h00;
      resp_active_q <= 1'b0;
    end else begin
      if (load) begin
        tx_valid_q <= 1'b1;
        tx_data_q  <= tx_byte.data;
      end else if (tx_ready) begin
        tx_valid_q <= 1'b0;
      end
      // stays up until a stalling host has taken the last byte
      resp_active_q <= (state_q inside {ST_HDR, ST_FETCH, ST_SUB, ST_TXCRC})
                       || (tx_valid_q && !tx_ready);
    end
  end

  // checksum over the received message, checksum bytes excluded
  cfgrd_crc16 u_rx_crc (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .init    (state_q == ST_ADDR),
    .en      (rx_valid && (state_q == ST_ADDR || state_q == ST_FUNC ||
              state_q == ST_BCNT || state_q == ST_ITEM)),
    .data    (rx_data),
    .crc_q   (rx_crc)
  );

  // checksum over the response, restarted by the address byte
  cfgrd_crc16 u_tx_crc (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .init    (state_q == ST_HDR && idx_q == HB_ADDR),
    .en      (load && (state_q == ST_HDR || state_q == ST_SUB)),
    .data    (tx_byte.data),
    .crc_q   (tx_crc)
  );

endmodule : cfgrd_responder

// *** verification/cfgrd_checker.sv ***
// port-level assertions for the configuration read responder
`timescale 1ns/1ps
module cfgrd_checker
  import cfgrd_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  dev_addr,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_frame_end,
  input wire logic        tx_valid_q,
  input wire logic [7:0]  tx_data_q,
  input wire logic        tx_ready,
  input wire logic [7:0]  param_tag_q,
  input wire logic [31:0] param_value,
  input wire logic        resp_active_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_first;
    $rose(tx_valid_q) && ($past(rx_frame_end, 2) || $past(rx_frame_end, 3));
  endsequence
  sequence s_sub_head;
    tx_valid_q && tx_data_q == (param_tag_q >= 8'h80 ? 8'h03 : 8'h05);
  endsequence

  a_hold_byte: assert property (
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
    else $error("byte changed before it was accepted");
  a_first_addr: assert property (
    s_first |-> tx_data_q == dev_addr)
    else $error("response does not open with own address");
  a_func_next: assert property (
    s_first ##0 tx_ready |=> tx_valid_q && tx_data_q == 8'h14)
    else $error("function code does not follow address");
  a_start_after_end: assert property (
    $rose(resp_active_q) |-> $past(rx_frame_end, 2) ||
      $past(rx_frame_end, 3))
    else $error("response started without a frame end");
  a_valid_in_resp: assert property (
    tx_valid_q |-> resp_active_q)
    else $error("byte offered outside a response");
  a_end_quiet: assert property (
    $fell(resp_active_q) |-> !tx_valid_q)
    else $error("byte still offered after response end");
  a_tag_range: assert property (
    $changed(param_tag_q) |-> param_tag_q inside {[8'h01:8'h7D]} ||
      param_tag_q >= 8'h80)
    else $error("lookup of an unsupported tag");
  a_tag_in_resp: assert property (
    $changed(param_tag_q) |-> resp_active_q)
    else $error("lookup outside a response");
  a_sub_count: assert property (
    $changed(param_tag_q) |-> (!tx_valid_q || $stable(tx_data_q))
      ##[1:3] s_sub_head)
    else $error("sub response count wrong or late");
endmodule : cfgrd_checker

// *** verification/cfgrd_host_model.sv ***
// host master side: collects response bytes, may stall every other cycle
`timescale 1ns/1ps
module cfgrd_host_model
  import cfgrd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       tx_valid_q,
  input  wire logic [7:0] tx_data_q,
  input  wire logic       stall,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       flip_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) flip_q <= 1'b0;
    else flip_q <= ~flip_q;
  end
  // a slow host refuses on alternate cycles to exercise the hold rule
  assign tx_ready = !stall || flip_q;

  always @(posedge sys_clk) begin
    if (rst_n && tx_valid_q && tx_ready) got.push_back(tx_data_q);
  end
endmodule : cfgrd_host_model

// *** verification/config_reference_read_responder_test.sv ***
// self-checking bench for the configuration read responder
`timescale 1ns/1ps
module config_reference_read_responder_test;
  import cfgrd_pkg::*;
  localparam logic [7:0] DEV = 8'h02;
  logic        sys_clk, rst_n, rx_valid, rx_frame_end, stall;
  logic [7:0]  rx_data;
  logic [31:0] param_value;
  logic        tx_valid_q, tx_ready, resp_active_q;
  logic [7:0]  tx_data_q, param_tag_q;
  logic [7:0]  frm[$];
  logic [7:0]  exp_q[$];
  int          fails, n_compared, cyc, w, cut;
  logic [7:0]  tags[8] = '{8'h01, 8'h7D, 8'h80, 8'hFF, 8'h40, 8'hC3,
                           8'h7C, 8'h81};
  int          bi[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 7, 8, 9, 10};

  function automatic logic [31:0] val(input logic [7:0] t);
    return {t, ~t, 8'hC0, t ^ 8'h5A};
  endfunction : val
  assign param_value = val(param_tag_q);

  cfgrd_responder uut (.sys_clk, .rst_n, .dev_addr(DEV), .rx_valid,
    .rx_data, .rx_frame_end, .tx_valid_q, .tx_data_q, .tx_ready,
    .param_tag_q, .param_value, .resp_active_q);
  cfgrd_host_model host (.sys_clk, .rst_n, .tx_valid_q, .tx_data_q,
    .stall, .tx_ready);

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string msg);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg,
               seen, want);
    end
  endtask : check

  task automatic add(input logic [7:0] t);
    logic [31:0] v;
    v = val(t);
    if (frm.size() == 0) frm = {DEV, 8'h14, 8'h00};
    frm = {frm, 8'h06, 8'h00, 8'h03, 8'h00, t, 8'h00,
           (t < 8'h80) ? 8'h02 : 8'h01};
    if (t < 8'h80) exp_q = {exp_q, 8'h05, 8'h06, v[31:24], v[23:16],
                            v[15:8], v[7:0]};
    else exp_q = {exp_q, 8'h03, 8'h06, v[15:8], v[7:0]};
  endtask : add

  // idx/m corrupt one byte of the request; m of zero sends it intact
  task automatic go(input int idx, input logic [7:0] m);
    logic [15:0] c;
    int          n;
    frm[2] = 8'(frm.size() - 3);
    n = frm.size();
    if (idx < n) frm[idx] ^= m;
    c = crc16(frm);
    frm = {frm, c[7:0], c[15:8]};
    if (idx >= n) frm[idx] ^= m;
    exp_q = {DEV, 8'h14, 8'(exp_q.size()), exp_q};
    c = crc16(exp_q);
    exp_q = {exp_q, c[7:0], c[15:8]};
    if (m != 8'h00 || cut != 0) exp_q.delete();
    host.got.delete();
    // a nonzero cut ends the frame early, after that many bytes
    foreach (frm[i]) if (cut == 0 || i < cut) begin
      rx_valid <= 1'b1;
      rx_data <= frm[i];
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_frame_end <= 1'b1;
    @(posedge sys_clk);
    rx_frame_end <= 1'b0;
    frm.delete();
  endtask : go

  task automatic done(input string nm);
    logic seen;
    seen = 1'b0;
    w = 0;
    while (w < 400 && !(seen && !resp_active_q)) begin
      @(posedge sys_clk);
      seen |= resp_active_q;
      w++;
    end
    check(host.got.size(), exp_q.size(), nm);
    foreach (exp_q[i]) if (i < host.got.size())
      check(host.got[i], exp_q[i], nm);
    exp_q.delete();
    $display("test %s done", nm);
  endtask : done

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // about 5600 cycles expected; the ceiling leaves a wide margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_frame_end = 1'b0;
    stall = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    add(8'h01);
    go(0, 8'h00);
    done("single float");
    stall <= 1'b1;
    foreach (tags[i]) add(tags[i]);
    go(0, 8'h00);
    done("eight mixed items, slow host");
    stall <= 1'b0;
    foreach (bi[i]) begin
      add(8'h01);
      go(bi[i], (i == 8) ? 8'h7F : 8'h01);
      done("corrupted request");
    end
    cut = 5;
    add(8'h01);
    go(0, 8'h00);
    done("frame cut short");
    cut = 0;
    add(8'h20);
    go(0, 8'h00);
    w = 0;
    while (!resp_active_q && w < 50) begin
      @(posedge sys_clk);
      w++;
    end
    @(posedge sys_clk);
    rst_n <= 1'b0;
    #1 check({tx_valid_q, resp_active_q}, 0, "reset abort");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    exp_q.delete();
    $display("test reset abort done");
    @(posedge sys_clk);
    add(8'hFF);
    add(8'h7D);
    go(0, 8'h00);
    done("integer then float after reset");
    finish_test();
  end
endmodule : config_reference_read_responder_test

bind cfgrd_responder cfgrd_checker chk (.sys_clk, .rst_n, .dev_addr,
  .rx_valid, .rx_data, .rx_frame_end, .tx_valid_q, .tx_data_q, .tx_ready,
  .param_tag_q, .param_value, .resp_active_q);
